//--- common/sdwd_pkg.sv
// shared constants, field layouts and types for the serial dac word decoder
package sdwd_pkg;

  localparam int NCH    = 8;
  localparam int CODE_W = 10;
  localparam int SUB_W  = 8;
  localparam int WORD_W = 16;
  localparam int CNT_W  = 5;
  localparam int IDX_W  = 3;

  // frame bit counting
  localparam logic [CNT_W-1:0] CNT_ZERO = 5'h00;
  localparam logic [CNT_W-1:0] CNT_ONE  = 5'h01;
  localparam logic [CNT_W-1:0] CNT_FULL = 5'h10;
  localparam logic [CNT_W-1:0] CNT_OVER = 5'h11;

  // system control word bit positions
  localparam int SYS_CODING_BIT = 6;
  localparam int SYS_PD_N_BIT   = 5;
  localparam int SYS_CHANNEL_STANDBY_N_BIT   = 4;
  localparam int SYS_CLR_BIT    = 3;

  // channel control word bit positions
  localparam int CH_REF_HI_BIT = 9;
  localparam int CH_REF_LO_BIT = 8;
  localparam int CH_CHANNEL_STANDBY_N_N_BIT = 4;
  localparam int CH_CLR_BIT    = 3;

  // sub code field position inside the payload
  localparam int SUB_LSB = 2;
  localparam int SUB_MSB = 9;

  // cleared codes and coding flips
  localparam logic [CODE_W-1:0] MAIN_CLR_CODE = 10'h000;
  localparam logic [CODE_W-1:0] MAIN_TOP_FLIP = 10'h200;
  localparam logic [SUB_W-1:0]  SUB_CLR_CODE  = 8'h00;
  localparam logic [SUB_W-1:0]  SUB_TOP_FLIP  = 8'h80;
  localparam logic [SUB_W-1:0]  SUB_NO_FLIP   = 8'h00;

  // control reset values
  localparam logic       CODING_RST = 1'b0;
  localparam logic       PD_N_RST   = 1'b1;
  localparam logic       GLOBAL_STANDBY_RST  = 1'b0;
  localparam logic       GLOBAL_SOFT_CLEAR_RST   = 1'b0;
  localparam logic [1:0] REF_RST    = 2'h0;
  localparam logic       CHANNEL_STANDBY_N_N_RST = 1'b1;
  localparam logic       CLR_RST    = 1'b0;

  // coding select values
  localparam logic CODING_TWOS   = 1'b0;
  localparam logic CODING_OFFSET = 1'b1;

  typedef struct packed {
    logic              main_sub;
    logic              dest_select_lo;
    logic              dest_select_hi;
    logic [IDX_W-1:0]  chan_addr;
    logic [CODE_W-1:0] payload;
  } sdwd_word_t;

  typedef struct packed {
    logic coding_select;
    logic power_down_n;
    logic global_standby;
    logic global_soft_clear;
  } sdwd_sys_ctrl_t;

  typedef struct packed {
    logic [1:0] ref_select;
    logic       channel_standby_n;
    logic       clear;
  } sdwd_chan_ctrl_t;

  typedef enum logic [1:0] {
    DEST_NONE,
    DEST_SYS,
    DEST_CHAN,
    DEST_DATA
  } sdwd_dest_t;

endpackage

//--- hw/sdwd_serial_rx.sv
// serial frame receiver: pin synchronisers, bit shifter and word framing
`timescale 1ns/1ps
module sdwd_serial_rx
  import sdwd_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic clk_en,
  input  wire logic frame_sync_n,
  input  wire logic serial_clock_in,
  input  wire logic serial_data_in,
  output logic      word_valid,
  output logic      frame_error,
  output sdwd_word_t word_data
);

  typedef enum logic {
    RX_IDLE,
    RX_SHIFT
  } sdwd_rx_state_t;

  logic [2:0]        sync1_r;
  logic [2:0]        sync2_r;
  logic              sclk_prev_r;
  logic [WORD_W-1:0] shift_r;
  logic [CNT_W-1:0]  cnt_r;
  logic [CNT_W-1:0]  cnt_nxt;
  sdwd_rx_state_t    state_r;
  sdwd_rx_state_t    state_nxt;
  logic              valid_r;
  logic              err_r;
  sdwd_word_t        word_r;

  wire fs_n_s   = sync2_r[0];
  wire sclk_s   = sync2_r[1];
  wire sdata_s  = sync2_r[2];
  wire sclk_fal = sclk_prev_r & ~sclk_s;
  wire frame_up = (state_r == RX_SHIFT) & fs_n_s;
  wire good     = frame_up & (cnt_r == CNT_FULL);
  wire cnt_sat  = (cnt_r == CNT_OVER);

  assign cnt_nxt = cnt_sat ? CNT_OVER : cnt_r + CNT_ONE;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      RX_IDLE: begin
        if (!fs_n_s) begin
          state_nxt = RX_SHIFT;
        end
      end
      RX_SHIFT: begin
        if (fs_n_s) begin
          state_nxt = RX_IDLE;
        end
      end
      default: begin
        state_nxt = RX_IDLE;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_r     <= 3'h7;
      sync2_r     <= 3'h7;
      sclk_prev_r <= 1'b1;
    end else if (clk_en) begin
      sync1_r     <= {serial_data_in, serial_clock_in, frame_sync_n};
      sync2_r     <= sync1_r;
      sclk_prev_r <= sclk_s;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= RX_IDLE;
      shift_r <= '0;
      cnt_r   <= CNT_ZERO;
    end else if (clk_en) begin
      state_r <= state_nxt;
      if (fs_n_s) begin
        cnt_r <= CNT_ZERO;
      end else if (sclk_fal) begin
        shift_r <= {shift_r[WORD_W-2:0], sdata_s};  // [R1] [R2]
        cnt_r   <= cnt_nxt;
      end
    end
  end

  // word acts only on exactly sixteen edges, else dropped
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      valid_r <= 1'b0;
      err_r   <= 1'b0;
      word_r  <= '0;
    end else if (clk_en) begin
      valid_r <= good;              // [R22]
      err_r   <= frame_up & ~good;  // [R22]
      if (good) begin
        word_r <= sdwd_word_t'(shift_r);
      end
    end
  end

  assign word_valid  = valid_r;
  assign frame_error = err_r;
  assign word_data   = word_r;

endmodule

//--- hw/sdwd_top.sv
// serial dac word decoder: command decode, control and double buffered codes
`timescale 1ns/1ps
// What this block does
// R1 - capture data on falling clock while sync low
// R2 - host shifts words most significant bit first
// R3 - bit 13 upper select, bit 14 lower
// R4 - 00 system, 01 channel, 1x data
// R5 - system write ignores channel address bits
// R6 - system word: coding, power, standby, clear bits
// R7 - channel write updates only addressed channel
// R8 - channel word: address, reference, standby, clear
// R9 - bit 15 picks main or sub data
// R10 - main write: address and ten bit code
// R11 - sub write: bits 9..2, ignore 1..0
// R12 - load falling copies all data registers together
// R13 - hardware clear resets data and output registers
// R14 - cleared main: lowest code or midscale
// R15 - zero scale differs by top bit flip
// R16 - cleared sub code means zero offset
// R17 - soft clears touch main registers only
// R18 - quad variant ignores top address bit
// R19 - coding 0 twos complement, 1 offset
// R20 - power down keeps all register contents
// R21 - host pulses load after channel clear change
// R22 - act only on exactly sixteen edges
module sdwd_top
  import sdwd_pkg::*;
#(
  parameter logic QUAD = 1'b0
)(
  input  wire logic                        clk,
  input  wire logic                        rst_n,
  input  wire logic                        clk_en,
  input  wire logic                        frame_sync_n,
  input  wire logic                        serial_clock_in,
  input  wire logic                        serial_data_in,
  input  wire logic                        load_outputs_n,
  input  wire logic                        clear_n,
  output logic [NCH-1:0][CODE_W-1:0]       main_code,
  output logic [NCH-1:0][SUB_W-1:0]        sub_offset,
  output logic [NCH-1:0][CODE_W-1:0]       main_pending,
  output logic [NCH-1:0][SUB_W-1:0]        sub_pending,
  output logic                             coding_select,
  output logic                             power_down_n,
  output logic                             global_standby,
  output logic                             global_soft_clear,
  output logic [NCH-1:0]                   channel_standby_n,
  output logic [NCH-1:0][1:0]              ref_select,
  output logic [NCH-1:0]                   channel_clear,
  output logic                             word_taken,
  output logic                             frame_error
);

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  // effective channel index; quad parts drop the top address bit
  function automatic logic [IDX_W-1:0] eff_index(input logic [IDX_W-1:0] a);
    logic [IDX_W-1:0] r;
    r = a;
    if (QUAD) begin
      r[IDX_W-1] = 1'b0;  // [R18]
    end
    return r;
  endfunction

  function automatic logic [NCH-1:0] one_hot(input logic [IDX_W-1:0] idx);
    logic [NCH-1:0] m;
    m = '0;
    m[idx] = 1'b1;
    return m;
  endfunction

  // offset binary sub codes become a signed offset, so zero stays zero
  function automatic logic [SUB_W-1:0] sub_signed(input logic [SUB_W-1:0] c, input logic coding);
    return (coding == CODING_OFFSET) ? (c ^ SUB_TOP_FLIP) : c;  // [R16]
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // serial receiver

  logic       rx_valid;
  logic       rx_err;
  sdwd_word_t rx_word;

  sdwd_serial_rx u_rx (
    .clk             (clk),
    .rst_n           (rst_n),
    .clk_en          (clk_en),
    .frame_sync_n    (frame_sync_n),
    .serial_clock_in (serial_clock_in),
    .serial_data_in  (serial_data_in),
    .word_valid      (rx_valid),
    .frame_error     (rx_err),
    .word_data       (rx_word)
  );

  ////////////////////////////////////////////////////////////////////////////
  // destination decode

  sdwd_dest_t       dest;
  logic [IDX_W-1:0] chan_idx;
  logic [NCH-1:0]   chan_sel;
  logic             wr_sys;
  logic             wr_chan;
  logic             wr_main;
  logic             wr_sub;
  logic [SUB_W-1:0] sub_field;

  // data words ignore the lower select bit
  always_comb begin
    dest = DEST_NONE;
    if (rx_valid) begin
      case ({rx_word.dest_select_hi, rx_word.dest_select_lo})  // [R3]
        2'h0:    dest = DEST_SYS;   // [R4]
        2'h1:    dest = DEST_CHAN;  // [R4]
        default: dest = DEST_DATA;  // [R4]
      endcase
    end
  end

  assign wr_sys  = (dest == DEST_SYS);
  assign wr_chan = (dest == DEST_CHAN);
  assign wr_main = (dest == DEST_DATA) & ~rx_word.main_sub;  // [R9]
  assign wr_sub  = (dest == DEST_DATA) & rx_word.main_sub;   // [R9]

  // address only matters for channel and data words
  assign chan_idx = eff_index(rx_word.chan_addr);  // [R5] [R10]
  assign chan_sel = one_hot(chan_idx);             // [R7]

  // sub codes are kept as a signed offset so that zero is zero offset
  assign sub_field = rx_word.payload[SUB_MSB:SUB_LSB];  // [R11]

  ////////////////////////////////////////////////////////////////////////////
  // load pin synchroniser and falling edge

  logic ld_s1_r;
  logic ld_s2_r;
  logic ld_prev_r;
  logic ld_fall;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ld_s1_r   <= 1'b1;
      ld_s2_r   <= 1'b1;
      ld_prev_r <= 1'b1;
    end else if (clk_en) begin
      ld_s1_r   <= load_outputs_n;
      ld_s2_r   <= ld_s1_r;
      ld_prev_r <= ld_s2_r;
    end
  end

  // edge only; a load pin held low updates once
  assign ld_fall = ld_prev_r & ~ld_s2_r;

  ////////////////////////////////////////////////////////////////////////////
  // system control register

  sdwd_sys_ctrl_t sys_r;
  sdwd_sys_ctrl_t sys_nxt;

  always_comb begin
    sys_nxt = sys_r;
    if (wr_sys) begin
      sys_nxt.coding_select     = rx_word.payload[SYS_CODING_BIT];  // [R6] [R19]
      sys_nxt.power_down_n      = rx_word.payload[SYS_PD_N_BIT];    // [R6] [R20]
      sys_nxt.global_standby    = rx_word.payload[SYS_CHANNEL_STANDBY_N_BIT];    // [R6]
      sys_nxt.global_soft_clear = rx_word.payload[SYS_CLR_BIT];     // [R6]
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sys_r <= '{CODING_RST, PD_N_RST, GLOBAL_STANDBY_RST, GLOBAL_SOFT_CLEAR_RST};
    end else if (clk_en) begin
      sys_r <= sys_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // channel control registers

  sdwd_chan_ctrl_t [NCH-1:0] ch_r;
  sdwd_chan_ctrl_t [NCH-1:0] ch_nxt;

  always_comb begin
    ch_nxt = ch_r;
    for (int i = 0; i < NCH; i++) begin
      if (wr_chan && chan_sel[i]) begin  // [R7]
        ch_nxt[i].ref_select        = {rx_word.payload[CH_REF_HI_BIT],
                                       rx_word.payload[CH_REF_LO_BIT]};  // [R8]
        ch_nxt[i].channel_standby_n = rx_word.payload[CH_CHANNEL_STANDBY_N_N_BIT];    // [R8]
        ch_nxt[i].clear             = rx_word.payload[CH_CLR_BIT];       // [R8]
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < NCH; i++) begin
        ch_r[i] <= '{REF_RST, CHANNEL_STANDBY_N_N_RST, CLR_RST};
      end
    end else if (clk_en) begin
      ch_r <= ch_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // double buffered codes

  // clear pin resets code storage at once; its release is retimed onto clk
  logic clr_in_n;
  logic clr_s1_r;
  logic clr_s2_r;
  logic hw_rst_n;

  assign clr_in_n = rst_n & clear_n;  // [R13]

  always_ff @(posedge clk or negedge clr_in_n) begin
    if (!clr_in_n) begin
      clr_s1_r <= 1'b0;
      clr_s2_r <= 1'b0;
    end else if (clk_en) begin
      clr_s1_r <= 1'b1;
      clr_s2_r <= clr_s1_r;
    end
  end

  assign hw_rst_n = clr_s2_r;

  logic [NCH-1:0][CODE_W-1:0] main_data_r;
  logic [NCH-1:0][CODE_W-1:0] main_data_nxt;
  logic [NCH-1:0][CODE_W-1:0] main_dac_r;
  logic [NCH-1:0][CODE_W-1:0] main_dac_nxt;
  logic [NCH-1:0][SUB_W-1:0]  sub_data_r;
  logic [NCH-1:0][SUB_W-1:0]  sub_data_nxt;
  logic [NCH-1:0][SUB_W-1:0]  sub_dac_r;
  logic [NCH-1:0][SUB_W-1:0]  sub_dac_nxt;

  // main code zero is lowest in offset binary and midscale in twos
  // complement, so one cleared value serves both codings
  always_comb begin
    main_data_nxt = main_data_r;
    main_dac_nxt  = main_dac_r;
    for (int i = 0; i < NCH; i++) begin
      if (wr_main && chan_sel[i]) begin
        main_data_nxt[i] = rx_word.payload;  // [R10]
      end
      if (ld_fall) begin
        main_dac_nxt[i] = main_data_r[i];  // [R12]
        // channel clear reapplies on every load until written to 0
        if (ch_r[i].clear) begin
          main_data_nxt[i] = MAIN_CLR_CODE;  // [R17] [R21]
          main_dac_nxt[i]  = MAIN_CLR_CODE;  // [R14] [R21]
        end
      end
      // soft clear wins over a same-cycle main write
      if (sys_r.global_soft_clear) begin
        main_data_nxt[i] = MAIN_CLR_CODE;  // [R14] [R17]
        main_dac_nxt[i]  = MAIN_CLR_CODE;  // [R14] [R17]
      end
    end
  end

  always_comb begin
    sub_data_nxt = sub_data_r;
    sub_dac_nxt  = sub_dac_r;
    for (int i = 0; i < NCH; i++) begin
      if (wr_sub && chan_sel[i]) begin
        sub_data_nxt[i] = sub_signed(sub_field, sys_r.coding_select);  // [R11] [R16]
      end
      if (ld_fall) begin
        sub_dac_nxt[i] = sub_data_r[i];  // [R12]
      end
    end
  end

  always_ff @(posedge clk or negedge hw_rst_n) begin
    if (!hw_rst_n) begin
      for (int i = 0; i < NCH; i++) begin
        main_data_r[i] <= MAIN_CLR_CODE;  // [R13] [R14] [R15]
        main_dac_r[i]  <= MAIN_CLR_CODE;  // [R13] [R14]
      end
    end else if (clk_en) begin
      main_data_r <= main_data_nxt;
      main_dac_r  <= main_dac_nxt;
    end
  end

  always_ff @(posedge clk or negedge hw_rst_n) begin
    if (!hw_rst_n) begin
      for (int i = 0; i < NCH; i++) begin
        sub_data_r[i] <= SUB_CLR_CODE;  // [R13] [R16]
        sub_dac_r[i]  <= SUB_CLR_CODE;  // [R13] [R16]
      end
    end else if (clk_en) begin
      sub_data_r <= sub_data_nxt;
      sub_dac_r  <= sub_dac_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // status pulses

  // word_taken rises with the register update it reports
  logic taken_r;
  logic err_r;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      taken_r <= 1'b0;
      err_r   <= 1'b0;
    end else if (clk_en) begin
      taken_r <= rx_valid;
      err_r   <= rx_err;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  // power down is a pure output level; no storage is touched by it
  assign coding_select     = sys_r.coding_select;
  assign power_down_n      = sys_r.power_down_n;  // [R20]
  assign global_standby    = sys_r.global_standby;
  assign global_soft_clear = sys_r.global_soft_clear;
  assign main_code         = main_dac_r;
  assign sub_offset        = sub_dac_r;
  assign main_pending      = main_data_r;
  assign sub_pending       = sub_data_r;
  assign word_taken        = taken_r;
  assign frame_error       = err_r;

  always_comb begin
    for (int i = 0; i < NCH; i++) begin
      channel_standby_n[i] = ch_r[i].channel_standby_n;
      ref_select[i]        = ch_r[i].ref_select;
      channel_clear[i]     = ch_r[i].clear;
    end
  end

endmodule

//--- bench/sdwd_props.sv
// concurrent checks on the decoder's top-level ports
`timescale 1ns/1ps
module sdwd_props
  import sdwd_pkg::*;
#(
  parameter logic QUAD = 1'b0
)(
  input wire logic                  clk,
  input wire logic                  rst_n,
  input wire logic                  frame_sync_n,
  input wire logic                  load_outputs_n,
  input wire logic                  clear_n,
  input wire logic [NCH-1:0][CODE_W-1:0] main_code,
  input wire logic [NCH-1:0][SUB_W-1:0]  sub_offset,
  input wire logic [NCH-1:0][CODE_W-1:0] main_pending,
  input wire logic [NCH-1:0][SUB_W-1:0]  sub_pending,
  input wire logic                  coding_select,
  input wire logic                  power_down_n,
  input wire logic                  global_soft_clear,
  input wire logic [NCH-1:0]        channel_standby_n,
  input wire logic                  word_taken,
  input wire logic                  frame_error
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  AST_TAKEN_PULSE: assert property (word_taken |=> !word_taken)
    else $error("word_taken longer than one cycle");
  AST_ERR_PULSE: assert property (frame_error |=> !frame_error)
    else $error("frame_error longer than one cycle");
  AST_EXCL: assert property (!(word_taken && frame_error))
    else $error("word_taken and frame_error together");
  AST_TAKEN_AFTER_FS: assert property (word_taken |-> frame_sync_n && $past(frame_sync_n, 4))
    else $error("word taken while frame still open");
  AST_ERR_AFTER_FS: assert property (frame_error |-> frame_sync_n)
    else $error("frame error while frame still open");
  AST_HWCLR_OUT: assert property (!clear_n |-> main_code == '0 && sub_offset == '0)
    else $error("output codes not cleared by clear_n");
  AST_HWCLR_PEND: assert property (!clear_n |-> main_pending == '0 && sub_pending == '0)
    else $error("pending codes not cleared by clear_n");
  AST_GLOBAL_SOFT_CLEAR_HOLD: assert property (global_soft_clear && $past(global_soft_clear)
    |-> main_code == '0 && main_pending == '0)
    else $error("main codes not held clear by soft clear");
  AST_SUB_ON_LOAD: assert property (clear_n && $past(clear_n) && $changed(sub_offset)
    |-> !$past(load_outputs_n, 2))
    else $error("sub output changed without load");
  AST_CTRL_WORD: assert property (($changed(coding_select) || $changed(power_down_n)) |-> word_taken)
    else $error("system control changed without a word");
  AST_CHANNEL_STANDBY_N_ONE: assert property ($changed(channel_standby_n)
    |-> $onehot(channel_standby_n ^ $past(channel_standby_n)))
    else $error("more than one channel control changed");
endmodule

bind sdwd_top sdwd_props #(.QUAD(QUAD)) u_props (
  .clk(clk), .rst_n(rst_n), .frame_sync_n(frame_sync_n), .load_outputs_n(load_outputs_n),
  .clear_n(clear_n), .main_code(main_code), .sub_offset(sub_offset), .main_pending(main_pending),
  .sub_pending(sub_pending), .coding_select(coding_select), .power_down_n(power_down_n),
  .global_soft_clear(global_soft_clear), .channel_standby_n(channel_standby_n),
  .word_taken(word_taken), .frame_error(frame_error)
);

//--- bench/sdwd_host.sv
// host model: frames command words onto the serial pins
`timescale 1ns/1ps
module sdwd_host (
  input  wire logic clk,
  output logic      frame_sync_n,
  output logic      serial_clock_in,
  output logic      serial_data_in
);
  initial begin
    frame_sync_n    = 1'b1;
    serial_clock_in = 1'b1;
    serial_data_in  = 1'b0;
  end

  // 320 ns serial period, n falling edges, clock parked high between frames
  task automatic send(input logic [15:0] w, input int n);
    @(posedge clk);
    frame_sync_n <= 1'b0;
    repeat (4) @(posedge clk);
    for (int i = 15; i > 15 - n; i--) begin
      serial_data_in  <= w[i];
      serial_clock_in <= 1'b1;
      repeat (4) @(posedge clk);
      serial_clock_in <= 1'b0;
      repeat (4) @(posedge clk);
    end
    serial_clock_in <= 1'b1;
    repeat (4) @(posedge clk);
    frame_sync_n   <= 1'b1;
    serial_data_in <= ~serial_data_in;
    repeat (2) @(posedge clk);
  endtask
endmodule

//--- bench/tb.sv
// self-checking bench for the serial dac word decoder
`timescale 1ns/1ps
module tb;
  import sdwd_pkg::*;
  logic clk = 1'b0;
  logic rst_n, load_outputs_n, clear_n, frame_sync_n, serial_clock_in, serial_data_in;
  logic [NCH-1:0][CODE_W-1:0] main_code, main_pending;
  logic [NCH-1:0][SUB_W-1:0]  sub_offset, sub_pending;
  logic coding_select, power_down_n, global_standby, global_soft_clear, word_taken, frame_error;
  logic [NCH-1:0]      channel_standby_n, channel_clear;
  logic [NCH-1:0][1:0] ref_select;
  int n_fail = 0;
  int n_tests = 0;

  always #20 clk = ~clk;

  sdwd_host host (.clk(clk), .frame_sync_n(frame_sync_n), .serial_clock_in(serial_clock_in),
    .serial_data_in(serial_data_in));
  sdwd_top dut (.clk(clk), .rst_n(rst_n), .clk_en(1'b1), .frame_sync_n(frame_sync_n),
    .serial_clock_in(serial_clock_in), .serial_data_in(serial_data_in), .load_outputs_n(load_outputs_n),
    .clear_n(clear_n), .main_code(main_code), .sub_offset(sub_offset), .main_pending(main_pending),
    .sub_pending(sub_pending), .coding_select(coding_select), .power_down_n(power_down_n),
    .global_standby(global_standby), .global_soft_clear(global_soft_clear),
    .channel_standby_n(channel_standby_n), .ref_select(ref_select), .channel_clear(channel_clear),
    .word_taken(word_taken), .frame_error(frame_error));

  ////////////////////////////////////////////////////////////////////////////
  task automatic test_done();
    $display("checks %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic chk(input string what, input logic [79:0] exp, input logic [79:0] got);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  // wait for word_taken (err=0) or frame_error (err=1), sampled at falling edges
  task automatic wait_pulse(input logic err);
    int k;
    for (k = 0; k < 40; k++) begin
      @(negedge clk);
      if ((err ? frame_error : word_taken) === 1'b1) break;
    end
    if (k == 40) begin
      n_fail++;
      test_done();
    end
    @(posedge clk);
  endtask

  task automatic wr(input logic [15:0] w);
    host.send(w, 16);
    wait_pulse(1'b0);
  endtask

  task automatic load();
    load_outputs_n <= 1'b0;
    repeat (6) @(posedge clk);
    load_outputs_n <= 1'b1;
    repeat (6) @(posedge clk);
    @(negedge clk);
  endtask

  // address field set to ones, it must be ignored
  function automatic logic [15:0] sysw(input logic c, input logic p, input logic s, input logic k);
    return {3'h0, 3'h7, 2'h0, 1'b0, c, p, s, k, 1'b0, 2'h0};
  endfunction
  function automatic logic [15:0] chw(input logic [2:0] a, input logic [1:0] r, input logic sn, input logic cl);
    return {3'h2, a, r, 3'h0, sn, cl, 1'b0, 2'h0};
  endfunction
  function automatic logic [15:0] dw(input logic sub, input logic lo, input logic [2:0] a, input logic [9:0] p);
    return {sub, lo, 1'b1, a, p};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    @(negedge clk);
    chk("coding", 80'(CODING_RST), 80'(coding_select));
    chk("pd_n", 80'(PD_N_RST), 80'(power_down_n));
    chk("standby_n", 80'h0ff, 80'(channel_standby_n));
    chk("main_code", 80'h0, 80'(main_code));
  endtask

  task automatic t_sys();
    wr(sysw(1'b1, 1'b0, 1'b1, 1'b0));
    chk("coding", 80'(CODING_OFFSET), 80'(coding_select));
    chk("pd_n", 80'h0, 80'(power_down_n));
    chk("gstby", 80'h1, 80'(global_standby));
    chk("standby_n", 80'h0ff, 80'(channel_standby_n));
    wr(dw(1'b1, 1'b0, 3'h2, 10'h200));
    chk("sub_pending2", 80'h0, 80'(sub_pending[2]));
    wr(sysw(1'b0, 1'b1, 1'b0, 1'b0));
    chk("coding", 80'(CODING_TWOS), 80'(coding_select));
    chk("pd_n", 80'h1, 80'(power_down_n));
  endtask

  task automatic t_chan();
    wr(chw(3'h5, 2'h2, 1'b0, 1'b0));
    chk("standby_n", 80'h0df, 80'(channel_standby_n));
    chk("ref_select", 80'h0800, 80'(ref_select));
  endtask

  task automatic t_data();
    wr(dw(1'b0, 1'b1, 3'h3, 10'h2a5));
    chk("main_pending3", 80'h2a5, 80'(main_pending[3]));
    chk("main_code3", 80'h0, 80'(main_code[3]));
    wr(dw(1'b1, 1'b0, 3'h3, 10'h16f));
    chk("sub_pending3", 80'h5b, 80'(sub_pending[3]));
    chk("main_pending3", 80'h2a5, 80'(main_pending[3]));
    load();
    chk("main_code3", 80'h2a5, 80'(main_code[3]));
    chk("sub_offset3", 80'h5b, 80'(sub_offset[3]));
  endtask

  task automatic t_partial();
    host.send(dw(1'b0, 1'b0, 3'h3, 10'h3ff), 15);
    wait_pulse(1'b1);
    chk("main_pending3", 80'h2a5, 80'(main_pending[3]));
  endtask

  task automatic t_global_soft_clear();
    wr(sysw(1'b0, 1'b1, 1'b0, 1'b1));
    @(negedge clk);
    chk("main_code", 80'h0, 80'(main_code));
    chk("main_pending", 80'h0, 80'(main_pending));
    chk("gsclr", 80'h1, 80'(global_soft_clear));
    chk("sub_offset3", 80'h5b, 80'(sub_offset[3]));
    wr(sysw(1'b0, 1'b1, 1'b0, 1'b0));
  endtask

  task automatic t_cclr();
    wr(dw(1'b0, 1'b0, 3'h3, 10'h155));
    load();
    chk("main_code3", 80'h155, 80'(main_code[3]));
    wr(chw(3'h3, 2'h0, 1'b1, 1'b1));
    chk("channel_clear", 80'h08, 80'(channel_clear));
    load();
    chk("main_code3", 80'h0, 80'(main_code[3]));
    chk("sub_offset3", 80'h5b, 80'(sub_offset[3]));
    wr(chw(3'h3, 2'h0, 1'b1, 1'b0));
    wr(dw(1'b0, 1'b0, 3'h7, 10'h3c3));
    load();
  endtask

  task automatic t_hwclr();
    chk("main_code7", 80'h3c3, 80'(main_code[7]));
    @(posedge clk);
    clear_n <= 1'b0;
    @(negedge clk);
    chk("main_code", 80'h0, 80'(main_code));
    chk("sub_offset", 80'h0, 80'(sub_offset));
    chk("pending", 80'h0, 80'(main_pending) | 80'(sub_pending));
    @(posedge clk);
    clear_n <= 1'b1;
    repeat (2) @(posedge clk);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    rst_n          = 1'b0;
    load_outputs_n = 1'b1;
    clear_n        = 1'b1;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    t_reset();
    t_sys();
    t_chan();
    t_data();
    t_partial();
    t_global_soft_clear();
    t_cclr();
    t_hwclr();
    test_done();
  end
endmodule
